// File: ssc_defines.svh
// register map, field positions, reset values and codes of the spi slave status block
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SSC_ADDR_W 12
`define SSC_OFF_CTRL0 12'h000
`define SSC_OFF_MODE_CTRL 12'h004
`define SSC_OFF_DATA 12'h008
`define SSC_OFF_IRQ_STAT 12'h00c
`define SSC_OFF_IRQ_MASK 12'h010

// ----------------------------------------------------------------
// control 0 fields
// ----------------------------------------------------------------
`define SSC_C0_INCOMPLETE 0
`define SSC_C0_ENABLE 1
`define SSC_C0_MODE_LO 5
`define SSC_C0_MODE_HI 7
`define SSC_C0_RST_MODE 3'h7
`define SSC_MODE_SPI_SLAVE 3'h5

// ----------------------------------------------------------------
// spi_mode_control fields
// ----------------------------------------------------------------
`define SSC_MC_DONE 0
`define SSC_MC_WRITE_COLLISION_FLAG 1
`define SSC_MC_SELECT_PIN_ENABLE 2
`define SSC_MC_ORDER 3
`define SSC_MC_EDGE 4
`define SSC_MC_POL 5
`define SSC_MC_RST 8'h00

// ----------------------------------------------------------------
// interrupt status / mask bits
// ----------------------------------------------------------------
`define SSC_IRQ_DONE 0
`define SSC_IRQ_INCOMPLETE 1
`define SSC_IRQ_W 2

// ----------------------------------------------------------------
// transfer
// ----------------------------------------------------------------
`define SSC_LAST_BIT 4'h7
`define SSC_CNT_ZERO 4'h0
`define SSC_CNT_ONE 4'h1

`endif

// File: ssc_pin_sync.sv
// three-stage synchroniser with agreement filter for the serial pins
`timescale 1ns/1ps
`default_nettype none
module ssc_pin_sync
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins from the master
  input wire ssc_pins_s raw,
  // filtered pins
  output ssc_pins_s clean
);

  ssc_sync_s st_q;
  ssc_sync_s st_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.s1 = raw;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // a change is accepted only when stages two and three agree
    if (st_q.s2 == st_q.s3) begin
      st_d.clean = st_q.s3;
    end
  end

  // ----------------------------------------------------------------
  // registers; select and clock idle high out of reset
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{s1: '{1'b1, 1'b1, 1'b0}, s2: '{1'b1, 1'b1, 1'b0},
                s3: '{1'b1, 1'b1, 1'b0}, clean: '{1'b1, 1'b1, 1'b0}};
    end else begin
      st_q <= st_d;
    end
  end

  assign clean = st_q.clean;

endmodule
`default_nettype wire

// File: ssc_pkg.sv
// types shared by the spi slave status block
package ssc_pkg;

  // ----------------------------------------------------------------
  // serial pins as seen by the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sck;
    logic slave_select_n;
    logic mosi;
  } ssc_pins_s;

  // ----------------------------------------------------------------
  // pin synchroniser state
  // ----------------------------------------------------------------
  typedef struct packed {
    ssc_pins_s s1;
    ssc_pins_s s2;
    ssc_pins_s s3;
    ssc_pins_s clean;
  } ssc_sync_s;

  // ----------------------------------------------------------------
  // apb request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ssc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ssc_apb_rsp_s;

  // ----------------------------------------------------------------
  // whole state of the main module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic interface_enable_bit;
    logic incomplete_transfer_flag;
    logic [7:0] spi_mode_control;
    logic [7:0] data;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic sel_prev;
    logic sck_prev;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic miso;
    logic miso_oe;
    ssc_apb_rsp_s rsp;
  } ssc_state_s;

endpackage

// File: ssc_spi_master_model.sv
// spi master model driving clock, select and data into the slave
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_master_model (
  // clock
  input wire logic pclk,
  // spi pins
  output logic sck,
  output logic slave_select_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sck = 1'b1;
    slave_select_n = 1'b1;
    mosi = 1'b0;
  end
  // frame of nb bits; sl low keeps select high
  task automatic xfer(input logic [7:0] tx, input int nb, input logic pol, input logic edg,
                      input logic msb, input logic sl, output logic [7:0] rx);
    int i;
    int k;
    rx = 8'h00;
    sck <= ~pol;
    repeat (4) @(posedge pclk);
    slave_select_n <= ~sl;
    repeat (8) @(posedge pclk);
    for (i = 0; i < nb; i++) begin
      k = msb ? 7 - i : i;
      mosi <= tx[k];
      repeat (4) @(posedge pclk);
      sck <= pol;
      repeat (2) @(posedge pclk);
      if (edg) rx[k] = miso;
      repeat (2) @(posedge pclk);
      sck <= ~pol;
      repeat (2) @(posedge pclk);
      if (!edg) rx[k] = miso;
      repeat (2) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
    slave_select_n <= 1'b1;
    mosi <= ~mosi;
    repeat (12) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: ssc_spi_slave.sv
// spi slave with incomplete-transfer detection, mode control register and apb access
`include "ssc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_slave
  import ssc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // spi pins
  input wire logic sck,
  input wire logic slave_select_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic bit_in, input logic msb_first);
    shift_in = msb_first ? {sr[6:0], bit_in} : {bit_in, sr[7:1]};
  endfunction

  function automatic logic out_bit(input logic [7:0] sr, input logic msb_first);
    out_bit = msb_first ? sr[7] : sr[0];
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  ssc_pins_s pins_raw;
  ssc_pins_s pins;

  assign pins_raw = '{sck: sck, slave_select_n: slave_select_n, mosi: mosi};

  ssc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw(pins_raw),
    .clean(pins)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ssc_state_s ST_RST = '{
    mode: `SSC_C0_RST_MODE,
    interface_enable_bit: 1'b0,
    incomplete_transfer_flag: 1'b0,
    spi_mode_control: `SSC_MC_RST,
    data: 8'h00,
    shreg: 8'h00,
    bitcnt: `SSC_CNT_ZERO,
    sel_prev: 1'b0,
    sck_prev: 1'b1,
    irq_stat: 2'h0,
    irq_mask: 2'h0,
    irq: 1'b0,
    miso: 1'b0,
    miso_oe: 1'b0,
    rsp: '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000}
  };

  ssc_state_s st_q;
  ssc_state_s st_d;

  logic slave_on;
  logic select_pin_enable;
  logic msb_first;
  logic sel;
  logic sck_rise;
  logic sck_fall;
  logic cap_edge;
  logic shift_edge;
  logic busy;
  logic wr_fire;
  logic addr_ok;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    rx_byte = 8'h00;
    rd_byte = 8'h00;

    slave_on = st_q.interface_enable_bit && (st_q.mode == `SSC_MODE_SPI_SLAVE);
    select_pin_enable = st_q.spi_mode_control[`SSC_MC_SELECT_PIN_ENABLE];
    msb_first = st_q.spi_mode_control[`SSC_MC_ORDER];
    // select line only matters when its pin is enabled
    sel = slave_on && (!select_pin_enable || !pins.slave_select_n);
    sck_rise = pins.sck && !st_q.sck_prev;
    sck_fall = !pins.sck && st_q.sck_prev;
    // capture on rising when polarity equals edge bit, else on falling
    cap_edge = (st_q.spi_mode_control[`SSC_MC_POL] == st_q.spi_mode_control[`SSC_MC_EDGE])
               ? sck_rise : sck_fall;
    shift_edge = (st_q.spi_mode_control[`SSC_MC_POL] == st_q.spi_mode_control[`SSC_MC_EDGE])
                 ? sck_fall : sck_rise;
    busy = sel && (st_q.bitcnt != `SSC_CNT_ZERO);

    addr_ok = (paddr == `SSC_OFF_CTRL0) || (paddr == `SSC_OFF_MODE_CTRL) || (paddr == `SSC_OFF_DATA) ||
              (paddr == `SSC_OFF_IRQ_STAT) || (paddr == `SSC_OFF_IRQ_MASK);
    wr_fire = psel && penable && st_q.rsp.pready && pwrite && addr_ok;

    // --------------------------------------------------------------
    // apb answer: one setup cycle, access phase always ready
    // --------------------------------------------------------------
    st_d.rsp.pready = psel && !penable && !st_q.rsp.pready;
    if (psel && !penable && !st_q.rsp.pready) begin
      st_d.rsp.pslverr = !addr_ok;
      case (paddr)
        `SSC_OFF_CTRL0: begin
          rd_byte[`SSC_C0_MODE_HI:`SSC_C0_MODE_LO] = st_q.mode;
          rd_byte[`SSC_C0_ENABLE] = st_q.interface_enable_bit;
          rd_byte[`SSC_C0_INCOMPLETE] = st_q.incomplete_transfer_flag;
        end
        `SSC_OFF_MODE_CTRL: rd_byte = st_q.spi_mode_control;
        `SSC_OFF_DATA: rd_byte = st_q.data;
        `SSC_OFF_IRQ_STAT: rd_byte[1:0] = st_q.irq_stat;
        `SSC_OFF_IRQ_MASK: rd_byte[1:0] = st_q.irq_mask;
        default: rd_byte = 8'h00;
      endcase
      st_d.rsp.prdata = {24'h00_0000, rd_byte};
    end else begin
      // answer stands for the access cycle only
      st_d.rsp.pslverr = 1'b0;
      st_d.rsp.prdata = 32'h0000_0000;
    end

    // --------------------------------------------------------------
    // software writes (hardware sets below take priority)
    // --------------------------------------------------------------
    if (wr_fire) begin
      case (paddr)
        `SSC_OFF_CTRL0: begin
          st_d.mode = pwdata[`SSC_C0_MODE_HI:`SSC_C0_MODE_LO];
          st_d.interface_enable_bit = pwdata[`SSC_C0_ENABLE];
          // plain store: touches no other flag
          st_d.incomplete_transfer_flag = pwdata[`SSC_C0_INCOMPLETE];
        end
        `SSC_OFF_MODE_CTRL: st_d.spi_mode_control = pwdata[7:0];
        `SSC_OFF_DATA: begin
          if (busy) begin
            st_d.spi_mode_control[`SSC_MC_WRITE_COLLISION_FLAG] = 1'b1;
          end else begin
            st_d.data = pwdata[7:0];
          end
        end
        `SSC_OFF_IRQ_STAT: st_d.irq_stat = st_q.irq_stat & ~pwdata[`SSC_IRQ_W-1:0];
        `SSC_OFF_IRQ_MASK: st_d.irq_mask = pwdata[`SSC_IRQ_W-1:0];
        default: st_d.irq_mask = st_q.irq_mask;
      endcase
    end

    // --------------------------------------------------------------
    // serial transfer
    // --------------------------------------------------------------
    st_d.sck_prev = pins.sck;
    st_d.sel_prev = sel;
    st_d.miso_oe = sel;
    if (sel && !st_q.sel_prev) begin
      // new selection: load byte and present its first bit
      st_d.shreg = st_q.data;
      st_d.bitcnt = `SSC_CNT_ZERO;
      st_d.miso = out_bit(st_q.data, msb_first);
    end else if (sel) begin
      if (cap_edge) begin
        rx_byte = shift_in(st_q.shreg, pins.mosi, msb_first);
        st_d.shreg = rx_byte;
        if (st_q.bitcnt == `SSC_LAST_BIT) begin
          st_d.bitcnt = `SSC_CNT_ZERO;
          st_d.data = rx_byte;
          st_d.spi_mode_control[`SSC_MC_DONE] = 1'b1;
          st_d.irq_stat[`SSC_IRQ_DONE] = 1'b1;
        end else begin
          st_d.bitcnt = st_q.bitcnt + `SSC_CNT_ONE;
        end
      end else if (shift_edge && st_q.bitcnt != `SSC_CNT_ZERO) begin
        st_d.miso = out_bit(st_q.shreg, msb_first);
      end
    end else begin
      st_d.bitcnt = `SSC_CNT_ZERO;
      // select released mid-byte while its pin is in use
      if (st_q.sel_prev && slave_on && select_pin_enable && st_q.bitcnt != `SSC_CNT_ZERO) begin
        st_d.incomplete_transfer_flag = 1'b1;
        st_d.spi_mode_control[`SSC_MC_DONE] = 1'b1;
        st_d.irq_stat[`SSC_IRQ_INCOMPLETE] = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // interrupt: level while an unmasked status bit is set
    // --------------------------------------------------------------
    st_d.irq = |(st_d.irq_stat & st_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st_q.rsp.prdata;
  assign pready = st_q.rsp.pready;
  assign pslverr = st_q.rsp.pslverr;
  assign miso = st_q.miso;
  assign miso_oe = st_q.miso_oe;
  assign irq = st_q.irq;

endmodule
`default_nettype wire

// File: ssc_spi_slave_props.sv
// assertions on the ports of the spi slave status block
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_slave_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // spi and interrupt
  input wire logic sck,
  input wire logic slave_select_n,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic irq
);
  logic [3:0] quiet_q;
  logic sck_q;
  logic ss_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles without bus access or change of clock or select pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_q <= 4'h0;
      sck_q <= 1'b1;
      ss_q <= 1'b1;
    end else begin
      sck_q <= sck;
      ss_q <= slave_select_n;
      if (psel || sck != sck_q || slave_select_n != ss_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  chk_ready_setup: assert property (s_setup |=> s_answer)
    else $error("ready not a single cycle after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  chk_data_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_bus_idle: assert property (!psel |=> !pready && !pslverr && prdata == 32'h0)
    else $error("answer without select");
  chk_unmapped_err: assert property (psel && !penable && !pready && paddr > 12'h010 |=> pslverr)
    else $error("unmapped address not refused");
  chk_irq_quiet: assert property (quiet_q >= 4'd12 |-> !$rose(irq))
    else $error("interrupt rose without cause");
  chk_miso_quiet: assert property (quiet_q >= 4'd12 |-> $stable(miso) && $stable(miso_oe))
    else $error("serial output moved without clock");
endmodule
bind ssc_spi_slave ssc_spi_slave_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck),
  .slave_select_n(slave_select_n), .miso(miso), .miso_oe(miso_oe), .irq(irq));
`default_nettype wire

// File: tb_spi_slave_status_and_clock_control.sv
// testbench of the spi slave status block
`include "ssc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_status_and_clock_control;
  localparam logic [11:0] a_c0 = `SSC_OFF_CTRL0;
  localparam logic [11:0] a_mc = `SSC_OFF_MODE_CTRL;
  localparam logic [11:0] a_dat = `SSC_OFF_DATA;
  localparam logic [11:0] a_st = `SSC_OFF_IRQ_STAT;
  localparam logic [11:0] a_mk = `SSC_OFF_IRQ_MASK;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic sck, slave_select_n, mosi, miso, miso_oe, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx, tx, mc;
  int err_count, compares, c;
  ssc_spi_slave i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck(sck), .slave_select_n(slave_select_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .irq(irq));
  ssc_spi_master_model i_mst (.pclk(pclk), .sck(sck), .slave_select_n(slave_select_n),
    .mosi(mosi), .miso(miso));
  // ----
  // tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      wrap_up;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (100000) @(posedge pclk);
    err_count++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(a_mc, 32'h00);
    rdc(a_c0, 32'he0);
    rdc(12'h020, 32'h0);
    check({31'h0, perr}, 32'h1);
    $display("test reset done");
    apb(1'b1, a_c0, 32'ha2);
    apb(1'b1, a_mk, 32'h1);
    for (c = 0; c < 4; c++) begin
      mc = {2'b00, c[1], c[0], ~c[0], 3'b100};
      tx = 8'h35 + 8'h22 * c[7:0];
      apb(1'b1, a_mc, {24'h0, mc});
      apb(1'b1, a_dat, {24'h0, tx});
      i_mst.xfer(~tx, 8, c[1], c[0], ~c[0], 1'b1, rx);
      check({24'h0, rx}, {24'h0, tx});
      rdc(a_dat, {24'h0, ~tx});
      rdc(a_mc, {24'h0, mc | 8'h01});
      check({31'h0, irq}, 32'h1);
      rdc(a_st, 32'h1);
      apb(1'b1, a_st, 32'h3);
      apb(1'b1, a_mc, {24'h0, mc});
      rdc(a_mc, {24'h0, mc});
      check({31'h0, irq}, 32'h0);
    end
    $display("test modes done");
    apb(1'b1, a_mc, 32'h0c);
    i_mst.xfer(8'h81, 3, 1'b0, 1'b0, 1'b1, 1'b1, rx);
    rdc(a_c0, 32'ha3);
    rdc(a_mc, 32'h0d);
    rdc(a_st, 32'h2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, a_mk, 32'h3);
    rdc(a_mk, 32'h3);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, a_st, 32'h3);
    apb(1'b1, a_c0, 32'ha2);
    apb(1'b1, a_mc, 32'h0c);
    rdc(a_c0, 32'ha2);
    $display("test incomplete done");
    apb(1'b1, a_c0, 32'ha3);
    rdc(a_mc, 32'h0c);
    rdc(a_st, 32'h0);
    rdc(a_c0, 32'ha3);
    apb(1'b1, a_c0, 32'ha2);
    $display("test software flag done");
    apb(1'b1, a_mc, 32'h08);
    i_mst.xfer(8'h5a, 8, 1'b0, 1'b0, 1'b1, 1'b0, rx);
    rdc(a_dat, 32'h5a);
    rdc(a_mc, 32'h09);
    apb(1'b1, a_mc, 32'h08);
    i_mst.xfer(8'h5a, 3, 1'b0, 1'b0, 1'b1, 1'b1, rx);
    rdc(a_c0, 32'ha2);
    rdc(a_mc, 32'h08);
    check({31'h0, miso_oe}, 32'h1);
    apb(1'b1, a_dat, 32'h33);
    rdc(a_mc, 32'h0a);
    rdc(a_dat, 32'h5a);
    $display("test select ignored done");
    apb(1'b1, a_c0, 32'he2);
    apb(1'b1, a_mc, 32'h0c);
    i_mst.xfer(8'h5a, 3, 1'b0, 1'b0, 1'b1, 1'b1, rx);
    rdc(a_c0, 32'he2);
    rdc(a_mc, 32'h0c);
    check({31'h0, miso_oe}, 32'h0);
    $display("test other mode done");
    wrap_up;
  end
endmodule
`default_nettype wire
